// ---- hw/esm_pkg.sv ----
// constants and types shared by the maintenance storage controller
package esm_pkg;
	// ==============================================================
	// storage geometry and ecc code layout
	localparam int DATA_W = 32;
	localparam int CODE_W = 39;
	localparam int POS_W = 6;
	localparam int CHK_W = 7;
	localparam int ADDR_W = 24;
	localparam int BLOCK_BYTES = 512;
	localparam int BLOCK_WORDS = 128;
	localparam int MEM_WORDS_DEF = 1024;
	// ==============================================================
	// register byte offsets
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_STATB = 8'h04;
	localparam logic [7:0] OFF_TGT_ADDR = 8'h08;
	localparam logic [7:0] OFF_TGT_DATA = 8'h0C;
	localparam logic [7:0] OFF_STOR_ADDR = 8'h10;
	localparam logic [7:0] OFF_LIMIT = 8'h14;
	localparam logic [7:0] OFF_ECC = 8'h18;
	localparam logic [7:0] OFF_CHK = 8'h1C;
	localparam logic [7:0] OFF_HFAULT = 8'h20;
	localparam logic [7:0] OFF_IRQ_ST = 8'h24;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
	localparam logic [7:0] OFF_INSTR_ADDR = 8'h2C;
	localparam logic [7:0] OFF_PREFETCH = 8'h30;
	// ==============================================================
	// command register fields and codes
	localparam int OP_LSB = 0;
	localparam int SZ_LSB = 4;
	localparam int INCR_BIT = 6;
	localparam int LOOP_BIT = 7;
	localparam int APAR_BIT = 8;
	localparam int DPAR_BIT = 9;
	localparam int CMD_W = 10;
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_WRITE = 3'h1;
	localparam logic [2:0] OP_READ = 3'h2;
	localparam logic [2:0] OP_SCAN = 3'h3;
	localparam logic [2:0] OP_PATTERN = 3'h4;
	localparam logic [2:0] OP_PREFETCH = 3'h5;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] SZ_RSV = 2'h3;
	localparam int BUSY_BIT = 0;
	// ==============================================================
	// ecc modes, hard fault fields, event bits
	localparam logic [1:0] ECC_OFF = 2'h0;
	localparam logic [1:0] ECC_ON = 2'h1;
	localparam logic [1:0] ECC_TRANSP = 2'h2;
	localparam int HF0_LSB = 0;
	localparam int HF0_EN = 7;
	localparam int HF1_LSB = 8;
	localparam int HF1_EN = 15;
	localparam int EV_DONE = 0;
	localparam int EV_AEXC = 1;
	localparam int EV_CORR = 2;
	localparam int EV_UNCORR = 3;
	localparam int EV_HCHK = 4;
	localparam int EV_W = 5;
	// ==============================================================
	// types
	typedef enum logic {st_idle, st_run} esm_state_type;
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
	} esm_ahb_req_type;
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic corr;
		logic uncorr;
	} esm_ecc_res_type;
endpackage

// ---- hw/esm_storage.sv ----
// maintenance storage controller with ecc, commands and ahb-lite registers
`timescale 1ns/1ps
module esm_storage #(
	parameter int MEM_WORDS = esm_pkg::MEM_WORDS_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// ahb-lite slave
	input esm_pkg::esm_ahb_req_type ahb_req,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// interrupt
	output logic irq
);
	import esm_pkg::*;

	localparam int IDX_W = $clog2(MEM_WORDS);
	localparam logic [ADDR_W-1:0] INST_BYTES = ADDR_W'(MEM_WORDS * 4);

	// ==============================================================
	// ecc helpers: hamming positions 1..38, overall parity at 0
	function automatic logic [CODE_W-1:0] ecc_encode(
		input logic [DATA_W-1:0] d);
		logic [CODE_W-1:0] c;
		int k;
		c = '0;
		k = 0;
		for (int p = 1; p < CODE_W; p++)
			if ((p & (p - 1)) != 0)
			begin
				c[p] = d[k];
				k++;
			end
		for (int b = 0; b < POS_W; b++)
			for (int p = 1; p < CODE_W; p++)
				if (((p >> b) & 1) != 0 && p != (1 << b))
					c[1 << b] = c[1 << b] ^ c[p];
		c[0] = ^c[CODE_W-1:1];
		return c;
	endfunction

	function automatic logic [DATA_W-1:0] ecc_data(
		input logic [CODE_W-1:0] c);
		logic [DATA_W-1:0] d;
		int k;
		d = '0;
		k = 0;
		for (int p = 1; p < CODE_W; p++)
			if ((p & (p - 1)) != 0)
			begin
				d[k] = c[p];
				k++;
			end
		return d;
	endfunction

	// check bits in order: overall, then positions 1,2,4,8,16,32
	function automatic logic [CODE_W-1:0] ecc_put_chk(
		input logic [CODE_W-1:0] c, input logic [CHK_W-1:0] k);
		logic [CODE_W-1:0] r;
		r = c;
		r[0] = k[0];
		for (int b = 0; b < POS_W; b++)
			r[1 << b] = k[b + 1];
		return r;
	endfunction

	function automatic esm_ecc_res_type ecc_try(
		input logic [CODE_W-1:0] c);
		esm_ecc_res_type r;
		logic [POS_W-1:0] syn;
		logic [CODE_W-1:0] f;
		syn = '0;
		f = c;
		r.corr = 1'b0;
		r.uncorr = 1'b0;
		for (int p = 1; p < CODE_W; p++)
			if (c[p])
				syn = syn ^ POS_W'(p);
		if (^c)
		begin
			if (int'(syn) < CODE_W)
			begin
				f[syn] = ~f[syn];
				r.corr = 1'b1;
			end
			else
				r.uncorr = 1'b1;
		end
		else if (syn != '0)
			r.uncorr = 1'b1;
		r.data = ecc_data(f);
		return r;
	endfunction

	// ==============================================================
	// registers and state
	esm_state_type state;
	logic [CMD_W-1:0] cmd;
	logic [ADDR_W-1:0] maint_target_addr_reg, storage_addr_reg;
	logic [ADDR_W-1:0] limit, instr_addr_reg;
	logic [DATA_W-1:0] maint_target_data_reg;
	logic [1:0] ecc_mode;
	logic [CHK_W-1:0] chk;
	logic [15:0] hfault;
	logic [EV_W-1:0] irq_st, irq_mask, ev_set;
	logic [15:0] pfa, pfb;
	logic [CODE_W-1:0] mem [MEM_WORDS];

	// bus phase
	logic ph_valid, ph_write, ph_map, rd_wait, wr_en;
	logic [7:0] ph_addr;

	// engine
	logic [2:0] op, new_op;
	logic [1:0] sz;
	logic incr, loop_eff, is_wr, access, cur_aexc, uncorr_hit;
	logic go, par_bad, sw_stop, finish;
	logic [ADDR_W-1:0] cur_addr, step;
	logic [IDX_W-1:0] idx;
	logic [CODE_W-1:0] hard_mask, raw, wr_code;
	esm_ecc_res_type dec1, dec2, rd;
	logic [DATA_W-1:0] lane_mask, wr_word, rd_field, rd_data;
	logic [4:0] sh;

	// ==============================================================
	// ahb-lite slave: zero-wait writes, one wait state on reads
	always_ff @(posedge clk)
		if (!nrst)
		begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr <= '0;
			ph_map <= 1'b0;
			rd_wait <= 1'b0;
		end
		else if (hready)
		begin
			ph_valid <= ahb_req.hsel && ahb_req.htrans[1];
			ph_write <= ahb_req.hwrite;
			ph_addr <= ahb_req.haddr[7:0];
			ph_map <= ahb_req.haddr[31:8] == '0 &&
				ahb_req.haddr[7:0] <= OFF_PREFETCH &&
				ahb_req.haddr[1:0] == 2'h0;
			rd_wait <= ahb_req.hsel && ahb_req.htrans[1] &&
				!ahb_req.hwrite;
		end
		else
			rd_wait <= 1'b0;

	assign hreadyout = !rd_wait;
	assign hresp = 1'b0;
	assign wr_en = ph_valid && ph_write && ph_map;

	always_ff @(posedge clk)
		if (!nrst)
			hrdata <= '0;
		else if (rd_wait)
		begin
			hrdata <= '0;
			if (ph_map)
				unique case (ph_addr)
					OFF_CMD: hrdata <= 32'(cmd);
					OFF_STATB: hrdata <= 32'(state == st_run);
					OFF_TGT_ADDR: hrdata <= 32'(maint_target_addr_reg);
					OFF_TGT_DATA: hrdata <= maint_target_data_reg;
					OFF_STOR_ADDR: hrdata <= 32'(storage_addr_reg);
					OFF_LIMIT: hrdata <= 32'(limit);
					OFF_ECC: hrdata <= 32'(ecc_mode);
					OFF_CHK: hrdata <= 32'(chk);
					OFF_HFAULT: hrdata <= 32'(hfault);
					OFF_IRQ_ST: hrdata <= 32'(irq_st);
					OFF_IRQ_MASK: hrdata <= 32'(irq_mask);
					OFF_INSTR_ADDR: hrdata <= 32'(instr_addr_reg);
					OFF_PREFETCH: hrdata <= {pfa, pfb};
					default: hrdata <= '0;
				endcase
		end

	// ==============================================================
	// command issue, parity check and stop request
	assign new_op = hwdata[OP_LSB +: 3];
	assign par_bad = wr_en && ph_addr == OFF_CMD && state == st_idle &&
		new_op != OP_NONE &&
		!((^{hwdata[APAR_BIT], maint_target_addr_reg}) &&
		(^{hwdata[DPAR_BIT], maint_target_data_reg}));
	assign go = wr_en && ph_addr == OFF_CMD && state == st_idle &&
		new_op != OP_NONE && !par_bad;
	assign sw_stop = wr_en && ph_addr == OFF_STATB && state == st_run &&
		!hwdata[BUSY_BIT];

	// ==============================================================
	// access datapath
	assign op = cmd[OP_LSB +: 3];
	assign sz = (op == OP_PREFETCH || cmd[SZ_LSB +: 2] == SZ_RSV) ?
		SZ_WORD : cmd[SZ_LSB +: 2];
	assign incr = cmd[INCR_BIT] && op != OP_PREFETCH;
	assign loop_eff = (cmd[LOOP_BIT] || op == OP_SCAN ||
		op == OP_PATTERN) && op != OP_PREFETCH;
	assign is_wr = op == OP_WRITE || op == OP_PATTERN;

	always_comb
	begin
		cur_addr = (op == OP_PREFETCH) ?
			{instr_addr_reg[ADDR_W-1:2], 2'h0} : maint_target_addr_reg;
		// fullword index is free of block order; blocks are 128 words
		idx = cur_addr[IDX_W+1:2];
		cur_aexc = cur_addr >= limit;
		access = state == st_run && !cur_aexc;
		step = ADDR_W'(1) << sz;
		hard_mask = '0;
		if (hfault[HF0_EN] && int'(hfault[HF0_LSB +: POS_W]) < CODE_W)
			hard_mask[hfault[HF0_LSB +: POS_W]] = 1'b1;
		if (hfault[HF1_EN] && int'(hfault[HF1_LSB +: POS_W]) < CODE_W)
			hard_mask[hfault[HF1_LSB +: POS_W]] = 1'b1;
		raw = mem[idx] ^ hard_mask;
		dec1 = ecc_try(raw);
		dec2 = ecc_try(raw ^ hard_mask);
		rd = dec1;
		// double error with one known stuck bit: retry with it inverted
		if (dec1.uncorr && $countones(hard_mask) == 1 && !dec2.uncorr)
		begin
			rd = dec2;
			rd.corr = 1'b1;
		end
		// two stuck bits or two soft bits stay uncorrectable
		if (ecc_mode != ECC_ON)
		begin
			rd.data = ecc_data(raw);
			rd.corr = 1'b0;
			rd.uncorr = 1'b0;
		end
		rd_data = rd.data;
		unique case (sz)
			SZ_BYTE:
			begin
				sh = {~cur_addr[1:0], 3'h0};
				lane_mask = 32'h0000_00FF << sh;
			end
			SZ_HALF:
			begin
				sh = {~cur_addr[1], 4'h0};
				lane_mask = 32'h0000_FFFF << sh;
			end
			default:
			begin
				sh = '0;
				lane_mask = 32'hFFFF_FFFF;
			end
		endcase
		wr_word = (rd.data & ~lane_mask) |
			((maint_target_data_reg << sh) & lane_mask);
		wr_code = ecc_encode(wr_word);
		if (ecc_mode == ECC_TRANSP)
			wr_code = ecc_put_chk(wr_code, chk);
		rd_field = (rd.data & lane_mask) >> sh;
		uncorr_hit = access && rd.uncorr &&
			!(is_wr && sz == SZ_WORD);
		finish = state == st_run &&
			(cur_aexc || uncorr_hit || !loop_eff);
	end

	// ==============================================================
	// storage array, zero after reset
	always_ff @(posedge clk)
		if (!nrst)
		begin
			for (int i = 0; i < MEM_WORDS; i++)
				mem[i] <= '0;
		end
		else if (access && is_wr && !uncorr_hit)
			mem[idx] <= wr_code;

	// ==============================================================
	// command state machine
	always_ff @(posedge clk)
		if (!nrst)
			state <= st_idle;
		else
			unique case (state)
				st_idle:
					if (go)
						state <= st_run;
				st_run:
					if (finish || sw_stop)
						state <= st_idle;
			endcase

	always_ff @(posedge clk)
		if (!nrst)
			cmd <= '0;
		else if (go)
			cmd <= hwdata[CMD_W-1:0];

	// target address, data and storage address registers
	always_ff @(posedge clk)
		if (!nrst)
		begin
			maint_target_addr_reg <= '0;
			maint_target_data_reg <= '0;
			storage_addr_reg <= '0;
		end
		else if (state == st_run)
		begin
			if (access)
			begin
				storage_addr_reg <= cur_addr;
				if (incr)
					maint_target_addr_reg <=
						maint_target_addr_reg + step;
				if (!is_wr && op != OP_PREFETCH)
					maint_target_data_reg <= rd_field;
			end
		end
		else if (wr_en)
		begin
			if (ph_addr == OFF_TGT_ADDR)
				maint_target_addr_reg <= hwdata[ADDR_W-1:0];
			if (ph_addr == OFF_TGT_DATA)
				maint_target_data_reg <= hwdata;
		end

	always_ff @(posedge clk)
		if (!nrst)
		begin
			pfa <= '0;
			pfb <= '0;
		end
		else if (access && op == OP_PREFETCH && !rd.uncorr)
		begin
			pfa <= rd.data[31:16];
			pfb <= rd.data[15:0];
		end

	// ==============================================================
	// configuration registers
	always_ff @(posedge clk)
		if (!nrst)
		begin
			limit <= INST_BYTES;
			ecc_mode <= ECC_ON;
			chk <= '0;
			hfault <= '0;
			instr_addr_reg <= '0;
			irq_mask <= '0;
		end
		else if (wr_en)
			unique case (ph_addr)
				OFF_LIMIT: limit <= (hwdata[ADDR_W-1:0] > INST_BYTES) ?
					INST_BYTES : hwdata[ADDR_W-1:0];
				OFF_ECC: ecc_mode <= hwdata[1:0];
				OFF_CHK: chk <= hwdata[CHK_W-1:0];
				OFF_HFAULT: hfault <= hwdata[15:0];
				OFF_INSTR_ADDR: instr_addr_reg <= hwdata[ADDR_W-1:0];
				OFF_IRQ_MASK: irq_mask <= hwdata[EV_W-1:0];
				default: ;
			endcase

	// ==============================================================
	// events and interrupt; a new event wins over a clear
	always_comb
	begin
		ev_set = '0;
		ev_set[EV_DONE] = finish || sw_stop;
		ev_set[EV_AEXC] = state == st_run && cur_aexc;
		ev_set[EV_CORR] = access && rd.corr;
		ev_set[EV_UNCORR] = uncorr_hit;
		ev_set[EV_HCHK] = uncorr_hit || par_bad;
	end

	always_ff @(posedge clk)
		if (!nrst)
			irq_st <= '0;
		else if (wr_en && ph_addr == OFF_IRQ_ST)
			irq_st <= (irq_st & ~hwdata[EV_W-1:0]) | ev_set;
		else
			irq_st <= irq_st | ev_set;

	assign irq = |(irq_st & irq_mask);

	// ==============================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence ran_s;
		state == st_run;
	endsequence
	sequence stopped_s;
		state == st_idle;
	endsequence

	issue_busy_a: assert property (go |=> ran_s)
		else $error("busy not raised after command issue");
	loop_busy_a: assert property (
		state == st_run && loop_eff && !finish && !sw_stop |=> ran_s)
		else $error("looping command lost busy");
	stop_halt_a: assert property (
		sw_stop |=> (stopped_s and irq_st[EV_DONE]))
		else $error("command kept running after busy cleared");
	single_end_a: assert property (
		state == st_run && !loop_eff |=> (stopped_s and irq_st[EV_DONE]))
		else $error("single command did not end");
	half_step_a: assert property (
		access && incr && sz == SZ_HALF |=> maint_target_addr_reg ==
		$past(maint_target_addr_reg) + ADDR_W'(2))
		else $error("halfword increment not by two");
	fixed_addr_a: assert property (
		access && !incr && op != OP_PREFETCH |=>
		maint_target_addr_reg == $past(maint_target_addr_reg) &&
		storage_addr_reg == $past(cur_addr))
		else $error("single address access moved the address");
	addr_exc_a: assert property (
		state == st_run && cur_aexc |=> (stopped_s and irq_st[EV_AEXC]))
		else $error("address exception did not end command");
	uncorr_a: assert property (
		uncorr_hit |=>
		(stopped_s and (irq_st[EV_HCHK] && irq_st[EV_UNCORR])))
		else $error("uncorrectable error not flagged");
	parity_a: assert property (
		par_bad |=> (stopped_s and irq_st[EV_HCHK]))
		else $error("parity error accepted as command");
	prefetch_a: assert property (
		access && op == OP_PREFETCH && !rd.uncorr |=>
		{pfa, pfb} == $past(rd_data))
		else $error("prefetch halves misplaced");
	one_soft_a: assert property (
		access && ecc_mode == ECC_ON && $countones(hard_mask) == 1 &&
		$countones(raw ^ hard_mask ^ ecc_encode(rd_data)) == 1 |->
		!rd.uncorr)
		else $error("soft plus hard error not corrected");
endmodule // esm_storage

// ---- testbench/esm_sp_model.sv ----
// service processor model: ahb-lite master for maintenance access
`timescale 1ns/1ps
module esm_sp_model (
	// clock
	input wire logic clk,
	// ahb-lite master side
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output esm_pkg::esm_ahb_req_type ahb_req,
	output logic [31:0] hwdata,
	// watchdog
	output logic tmo
);
	import esm_pkg::*;

	initial
	begin
		ahb_req = '0;
		hwdata = 32'h0000_0000;
		tmo = 1'b0;
	end

	// ==============================================================
	// bus cycles
	task automatic wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hready !== 1'b1 && n < 64);
		if (hready !== 1'b1)
			tmo <= 1'b1;
	endtask

	task automatic xfer(input logic wr_en, input logic [7:0] off,
		input logic [31:0] d, output logic [31:0] q);
		ahb_req <= '{1'b1, {24'h00_0000, off}, 2'b10, wr_en, 3'b010};
		wait_rdy();
		ahb_req <= '0;
		if (wr_en)
			hwdata <= d;
		wait_rdy();
		q = hrdata;
		// released data lines do not keep the last value
		hwdata <= ~d;
	endtask

	// a looping command is halted by clearing the busy bit
	task automatic stop_cmd;
		logic [31:0] q;
		xfer(1'b1, OFF_STATB, 32'h0000_0000, q);
	endtask
endmodule // esm_sp_model

// ---- testbench/esm_storage_tb_top.sv ----
// self-checking bench of the maintenance storage controller
`timescale 1ns/1ps
module esm_storage_tb_top;
	import esm_pkg::*;
	localparam int MW = 512;
	localparam logic [9:0] WRW = 10'h021;
	localparam logic [9:0] RDW = 10'h022;
	localparam logic [9:0] WRB = 10'h001;
	localparam logic [9:0] RDB = 10'h002;
	localparam logic [9:0] WHI = 10'h051;
	localparam logic [9:0] RHI = 10'h052;
	localparam logic [9:0] RDH = 10'h012;
	localparam logic [9:0] PFW = 10'h005;
	localparam logic [9:0] PAT = 10'h0D4;
	localparam logic [9:0] SCAN = 10'h0A3;
	typedef struct packed {
		logic [9:0] c;
		logic [23:0] a;
		logic [31:0] d;
		logic [31:0] em;
	} esm_row_type;
	typedef struct packed {
		logic [31:0] d;
		logic [31:0] hf;
		logic [31:0] ev;
	} esm_ecc_row_type;
	localparam esm_row_type ROWS [0:15] = '{
		'{WRW, 24'h00_0000, 32'h1122_3344, 32'h1122_3344},
		'{WRB, 24'h00_0000, 32'h0000_00AA, 32'h0000_00AA},
		'{RDB, 24'h00_0000, 32'h0000_0000, 32'h0000_00AA},
		'{RDW, 24'h00_0000, 32'h0000_0000, 32'hAA22_3344},
		'{WHI, 24'h00_0004, 32'h0000_AAAA, 32'h0000_AAAA},
		'{RHI, 24'h00_0004, 32'h0000_0000, 32'h0000_AAAA},
		'{RDH, 24'h00_0006, 32'h0000_0000, 32'h0000_0000},
		'{WRW, 24'h00_01FC, 32'h5A5A_0001, 32'h5A5A_0001},
		'{WRW, 24'h00_0200, 32'hC3C3_0002, 32'hC3C3_0002},
		'{RDW, 24'h00_0400, 32'h0000_0000, 32'h0000_0000},
		'{RDW, 24'h00_0600, 32'h0000_0000, 32'h0000_0000},
		'{RDW, 24'h00_0000, 32'h0000_0000, 32'hAA22_3344},
		'{RDW, 24'h00_01FC, 32'h0000_0000, 32'h5A5A_0001},
		'{RDW, 24'h00_0200, 32'h0000_0000, 32'hC3C3_0002},
		'{WRW, 24'h00_0000, 32'hAAAA_5555, 32'hAAAA_5555},
		'{PFW, 24'h00_0000, 32'hAAAA_5555, 32'hAAAA_5555}
	};
	localparam esm_ecc_row_type ECCT [0:2] = '{
		'{32'h0000_0001, 32'h0000_0081, 32'h0000_0004},
		'{32'h0000_0000, 32'h0000_8281, 32'h0000_0018},
		'{32'h0000_0003, 32'h0000_0000, 32'h0000_0018}
	};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	wire logic hready;
	esm_ahb_req_type ahb_req;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic irq;
	logic tmo;
	int err_total = 0;
	int num_checks = 0;

	assign hready = hreadyout;
	always #50 clk = ~clk;

	esm_storage #(.MEM_WORDS(MW)) u_esm_storage (
		.clk(clk), .nrst(nrst), .ahb_req(ahb_req), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .irq(irq)
	);
	esm_sp_model u_esm_sp_model (
		.clk(clk), .hready(hready), .hrdata(hrdata),
		.ahb_req(ahb_req), .hwdata(hwdata), .tmo(tmo)
	);

	// ==============================================================
	// shared tasks
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] off, input logic [31:0] d);
		logic [31:0] q;
		u_esm_sp_model.xfer(1'b1, off, d, q);
	endtask

	task automatic rd(input logic [7:0] off, output logic [31:0] q);
		u_esm_sp_model.xfer(1'b0, off, 32'h0000_0000, q);
	endtask

	task automatic rv(input string nm, input logic [7:0] off,
		input logic [31:0] e);
		logic [31:0] q;
		rd(off, q);
		chk(nm, q, e);
	endtask

	// command with odd parity over target address and data
	task automatic issue(input logic [9:0] c);
		logic [31:0] a;
		logic [31:0] d;
		rd(OFF_TGT_ADDR, a);
		rd(OFF_TGT_DATA, d);
		c[APAR_BIT] = ~^a[23:0];
		c[DPAR_BIT] = ~^d;
		wr(OFF_CMD, {22'h00_0000, c});
	endtask

	task automatic idle;
		logic [31:0] s;
		int n;
		n = 0;
		s = 32'h0000_0001;
		while (s[BUSY_BIT] !== 1'b0 && n < 400)
		begin
			rd(OFF_STATB, s);
			n++;
		end
		if (s[BUSY_BIT] !== 1'b0)
		begin
			err_total++;
			stop_test();
		end
	endtask

	task automatic acc(input logic [9:0] c, input logic [23:0] a,
		input logic [31:0] d);
		wr(OFF_TGT_ADDR, {8'h00, a});
		wr(OFF_TGT_DATA, d);
		issue(c);
		idle();
	endtask

	always @(posedge tmo)
	begin
		err_total++;
		stop_test();
	end

	// ==============================================================
	// main sequence
	initial
	begin
		logic [31:0] q;
		logic [23:0] st;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk("hresp", hresp, 32'h0000_0000);
		chk("irq", irq, 32'h0000_0000);
		rv("limit", OFF_LIMIT, 32'h0000_0800);
		rv("ecc_mode", OFF_ECC, 32'h0000_0001);
		rv("busy", OFF_STATB, 32'h0000_0000);
		wr(8'h34, 32'hFFFF_FFFF);
		rv("unmapped", 8'h34, 32'h0000_0000);
		$display("test reset done");
		wr(OFF_INSTR_ADDR, 32'h0000_0000);
		foreach (ROWS[i])
		begin
			acc(ROWS[i].c, ROWS[i].a, ROWS[i].d);
			st = ROWS[i].c[INCR_BIT] ? 24'h00_0001 << ROWS[i].c[5:4] : '0;
			rv("target_data", OFF_TGT_DATA, ROWS[i].em);
			rv("storage_addr", OFF_STOR_ADDR, {8'h00, ROWS[i].a});
			rv("target_addr", OFF_TGT_ADDR, {8'h00, ROWS[i].a + st});
		end
		rv("prefetch", OFF_PREFETCH, 32'hAAAA_5555);
		$display("test rows done");
		wr(OFF_IRQ_ST, 32'h0000_001F);
		wr(OFF_IRQ_MASK, 32'h0000_0008);
		wr(OFF_CHK, 32'h0000_0000);
		foreach (ECCT[i])
		begin
			wr(OFF_ECC, {30'h0000_0000, ECC_TRANSP});
			acc(WRW, 24'h00_0100, ECCT[i].d);
			wr(OFF_ECC, {30'h0000_0000, ECC_ON});
			wr(OFF_HFAULT, ECCT[i].hf);
			acc(RDW, 24'h00_0100, 32'h0000_0000);
			wr(OFF_HFAULT, 32'h0000_0000);
			rd(OFF_IRQ_ST, q);
			chk("ecc_events", q & 32'h0000_001C, ECCT[i].ev);
			chk("irq", irq, ECCT[i].ev[EV_UNCORR]);
			if (ECCT[i].ev[EV_UNCORR] !== 1'b1)
				rv("corrected", OFF_TGT_DATA, 32'h0000_0000);
			wr(OFF_IRQ_ST, 32'h0000_001F);
			#1;
			chk("irq_clear", irq, 32'h0000_0000);
		end
		$display("test ecc done");
		wr(OFF_TGT_ADDR, 32'h0000_0000);
		wr(OFF_CMD, {22'h00_0000, WRW});
		idle();
		rd(OFF_IRQ_ST, q);
		chk("hard_check", q[EV_HCHK], 32'h0000_0001);
		acc(RDW, 24'h00_0000, 32'h0000_0000);
		rv("no_write", OFF_TGT_DATA, 32'hAAAA_5555);
		wr(OFF_IRQ_ST, 32'h0000_001F);
		$display("test parity done");
		wr(OFF_ECC, {30'h0000_0000, ECC_OFF});
		wr(OFF_LIMIT, 32'h0000_0200);
		wr(OFF_TGT_ADDR, 32'h0000_0000);
		wr(OFF_TGT_DATA, 32'h0000_AAAA);
		issue(PAT);
		rv("busy", OFF_STATB, 32'h0000_0001);
		idle();
		rd(OFF_IRQ_ST, q);
		chk("addr_exception", q[EV_AEXC], 32'h0000_0001);
		wr(OFF_LIMIT, 32'h0000_0800);
		wr(OFF_ECC, {30'h0000_0000, ECC_ON});
		acc(RDW, 24'h00_01FC, 32'h0000_0000);
		rv("last_word", OFF_TGT_DATA, 32'hAAAA_AAAA);
		acc(RDW, 24'h00_0200, 32'h0000_0000);
		rv("next_card", OFF_TGT_DATA, 32'hC3C3_0002);
		$display("test pattern done");
		wr(OFF_TGT_ADDR, 32'h0000_0200);
		issue(SCAN);
		rv("busy", OFF_STATB, 32'h0000_0001);
		repeat (20) @(posedge clk);
		rv("busy", OFF_STATB, 32'h0000_0001);
		u_esm_sp_model.stop_cmd();
		rv("stopped", OFF_STATB, 32'h0000_0000);
		rv("storage_addr", OFF_STOR_ADDR, 32'h0000_0200);
		rv("target_addr", OFF_TGT_ADDR, 32'h0000_0200);
		rv("target_data", OFF_TGT_DATA, 32'hC3C3_0002);
		$display("test stop done");
		// reset in the middle of a running scan
		issue(SCAN);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rv("busy_after_reset", OFF_STATB, 32'h0000_0000);
		rv("target_addr_reset", OFF_TGT_ADDR, 32'h0000_0000);
		rv("irq_st_reset", OFF_IRQ_ST, 32'h0000_0000);
		$display("test reset in run done");
		stop_test();
	end
endmodule // esm_storage_tb_top
